// ===== bsa_pkg.sv
/*
 * Package for the self-test and sensor alarm configuration bank: register
 * offsets, field positions, reset values, codes and carrier structs.
 * Assumes an 8-bit register port with byte offsets.
 */
package bsa_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LVL_W  = 3;

    // register offsets
    localparam logic [7:0] OFS_SELFTEST  = 8'h14;
    localparam logic [7:0] OFS_VGAIN     = 8'h15;
    localparam logic [7:0] OFS_RSVD16    = 8'h16;
    localparam logic [7:0] OFS_MONCTL0   = 8'h17;
    localparam logic [7:0] OFS_MONCTL1   = 8'h18;
    localparam logic [7:0] OFS_V0_LIM    = 8'h19;
    localparam logic [7:0] OFS_V1_LIM    = 8'h1A;
    localparam logic [7:0] OFS_T_LIM     = 8'h1B;
    localparam logic [7:0] OFS_CSI_EN    = 8'h1C;
    localparam logic [7:0] OFS_SENSE_EN  = 8'h1D;

    // reset values
    localparam logic [7:0] RST_SELFTEST  = 8'h00;
    localparam logic [7:0] RST_VGAIN     = 8'h20;
    localparam logic [7:0] RST_RSVD16    = 8'h18;
    localparam logic [7:0] RST_MONCTL0   = 8'h0C;
    localparam logic [7:0] RST_MONCTL1   = 8'h80;
    localparam logic [7:0] RST_LIMITS    = 8'h62;
    localparam logic [7:0] RST_CSI_EN    = 8'h3F;
    localparam logic [7:0] RST_SENSE_EN  = 8'h00;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    // field positions
    localparam int unsigned FERR_LSB  = 4;
    localparam int unsigned FERR_MSB  = 7;
    localparam int unsigned LBIST_BIT = 3;
    localparam int unsigned CLKS_LSB  = 1;
    localparam int unsigned CLKS_MSB  = 2;
    localparam int unsigned RBIST_BIT = 0;
    localparam int unsigned GAIN_MSB  = 6;
    localparam int unsigned GAIN_LSB  = 0;
    localparam int unsigned SEN_LSB   = 2;
    localparam int unsigned SEN_MSB   = 3;
    localparam int unsigned PIN_LSB   = 0;
    localparam int unsigned PIN_MSB   = 1;
    localparam int unsigned GAINEN_BIT= 7;
    localparam int unsigned HI_LSB    = 4;
    localparam int unsigned HI_MSB    = 6;
    localparam int unsigned LO_LSB    = 0;
    localparam int unsigned LO_MSB    = 2;
    localparam int unsigned NFV_BIT   = 5;
    localparam int unsigned SYNC_BIT  = 4;
    localparam int unsigned CTRL_BIT  = 3;
    localparam int unsigned ECC2_BIT  = 2;
    localparam int unsigned CHK_BIT   = 1;
    localparam int unsigned LEN_BIT   = 0;
    localparam int unsigned T_OV_BIT  = 5;
    localparam int unsigned T_UN_BIT  = 4;
    localparam int unsigned V1_OV_BIT = 3;
    localparam int unsigned V1_UN_BIT = 2;
    localparam int unsigned V0_OV_BIT = 1;
    localparam int unsigned V0_UN_BIT = 0;
    localparam int unsigned CSI_W     = 6;
    localparam int unsigned SENSE_W   = 6;

    localparam logic [1:0] SEN_ON     = 2'h3;
    localparam logic [6:0] GAIN_UNITY = 7'h00;
    localparam logic [7:0] GAIN_NUM   = 8'h80;

    typedef enum logic [1:0] {
        BSA_CLK_EXT  = 2'b00,
        BSA_CLK_50M  = 2'b01,
        BSA_CLK_25M  = 2'b10
    } bsa_clk_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bsa_bus_s;

    // three-bit quantised sensor readings
    typedef struct packed {
        logic [LVL_W-1:0] volt0;
        logic [LVL_W-1:0] volt1;
        logic [LVL_W-1:0] temp;
    } bsa_meas_s;

    typedef struct packed {
        logic [3:0] forced_error_count;
        logic       local_selftest_enable;
        bsa_clk_e   selftest_clock_select;
        logic       legacy_remote_selftest_enable;
        logic       force_active;
    } bsa_test_s;

    typedef struct packed {
        logic [6:0] voltage_gain_code;
        logic       gain_applied;
        logic       sensors_on;
        logic       pin0_sense;
        logic       pin1_sense;
    } bsa_mon_s;

endpackage : bsa_pkg

// ===== bsa_limit_cmp.sv
/*
 * One limit comparator: raises over and under flags for a quantised reading
 * against programmed upper and lower levels while the channel is active.
 * Assumes the reading is already in the clock domain.
 */
`timescale 1ns/10ps
module bsa_limit_cmp (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       active_i,
    input  wire logic [2:0] level_i,
    input  wire logic [2:0] upper_i,
    input  wire logic [2:0] lower_i,
    output logic            over_o,
    output logic            under_o
);
    import bsa_pkg::*;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            over_o  <= 1'b0;
            under_o <= 1'b0;
        end
        else
        begin
            over_o  <= active_i && (level_i > upper_i);
            under_o <= active_i && (level_i < lower_i);
        end
    end

endmodule : bsa_limit_cmp

// ===== bsa_sync2.sv
/*
 * Two-flop synchroniser for a bus of levels from outside the clock domain.
 * Assumes each bit is a slowly changing level.
 */
`timescale 1ns/10ps
module bsa_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r <= '0;
            q_o    <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule : bsa_sync2

// ===== bsa_config_regs.sv
/*
 * Self-test and sensor alarm configuration bank: ten 8-bit registers, limit
 * comparators on the sensor readings, and alarm gating of sensor and camera
 * receive events. Assumes a single clock; readings and receive error levels
 * arrive from outside and are synchronised here.
 */
// Decided for this implementation: the address-and-strobe port.
// Functional notes
// - nonzero four-bit error-forcing field injects forward-channel errors; zero disables.
// - local self-test bit puts device in self-test without remote command.
// - clock select 00 external, 01 fifty MHz internal, 1x twenty-five MHz.
// - bit 0 is a legacy remote self-test enable, reset zero.
// - seven-bit gain code gives gain 128 over code, reset 0x20.
// - sensor enable field 11 enables, 00 disables, reset enabled.
// - pin sensing field selects none, pin 0, pin 1 or both.
// - gain applies only while gain-enable bit is set, reset one.
// - pin 0 reading above upper limit flags channel 0 over.
// - pin 0 reading below lower limit flags channel 0 under.
// - pin 1 upper limit sets channel 1 over level.
// - pin 1 lower limit sets channel 1 under level.
// - enabled temperature above upper limit flags over-temperature.
// - enabled temperature below lower limit flags under-temperature.
// - enables for missing frame, phy sync, phy control alarms, reset one.
// - enables for ECC, checksum, length alarms, reset one.
// - temperature over and under alarm enables at bits 5 and 4.
// - channel 1 over and under alarm enables at bits 3 and 2.
// - channel 0 over and under alarm enables at bits 1 and 0.
`timescale 1ns/10ps
module bsa_config_regs (
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    input  wire bsa_pkg::bsa_bus_s    bus_i,
    output logic [bsa_pkg::DATA_W-1:0] rdata_o,
    input  wire bsa_pkg::bsa_meas_s   meas_i,
    input  wire logic [5:0]           csi_err_i,
    output bsa_pkg::bsa_test_s        test_o,
    output bsa_pkg::bsa_mon_s         mon_o,
    output logic [5:0]                sense_flags_o,
    output logic [5:0]                sense_alarm_o,
    output logic [5:0]                csi_alarm_o
);
    import bsa_pkg::*;

    logic [7:0] selftest_r;
    logic [7:0] vgain_r;
    logic [7:0] rsvd16_r;
    logic [7:0] monctl0_r;
    logic [7:0] monctl1_r;
    logic [7:0] v0lim_r;
    logic [7:0] v1lim_r;
    logic [7:0] tlim_r;
    logic [7:0] csien_r;
    logic [7:0] senseen_r;
    logic [7:0] rdata_nxt;

    bsa_meas_s  meas_s;
    logic [5:0] csi_s;
    logic       sensors_on;
    logic       pin0_on;
    logic       pin1_on;
    logic       chan0_over_flag;
    logic       chan0_under_flag;
    logic       chan1_over_flag;
    logic       chan1_under_flag;
    logic       temp_over_flag;
    logic       temp_under_flag;

    // register writes
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            selftest_r <= RST_SELFTEST;
            vgain_r    <= RST_VGAIN;
            rsvd16_r   <= RST_RSVD16;
            monctl0_r  <= RST_MONCTL0;
            monctl1_r  <= RST_MONCTL1;
            v0lim_r    <= RST_LIMITS;
            v1lim_r    <= RST_LIMITS;
            tlim_r     <= RST_LIMITS;
            csien_r    <= RST_CSI_EN;
            senseen_r  <= RST_SENSE_EN;
        end
        else if (bus_i.wr)
        begin
            if (bus_i.addr == OFS_SELFTEST)
                selftest_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_VGAIN)
                vgain_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_RSVD16)
                rsvd16_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_MONCTL0)
                monctl0_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_MONCTL1)
                monctl1_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_V0_LIM)
                v0lim_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_V1_LIM)
                v1lim_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_T_LIM)
                tlim_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_CSI_EN)
                csien_r <= bus_i.wdata;
            else if (bus_i.addr == OFS_SENSE_EN)
                senseen_r <= bus_i.wdata;
        end
    end

    // read mux: all bits read back as written; unmapped offsets read zero
    always_comb
    begin
        rdata_nxt = RD_UNMAPPED;
        if (bus_i.addr == OFS_SELFTEST)
            rdata_nxt = selftest_r;
        else if (bus_i.addr == OFS_VGAIN)
            rdata_nxt = vgain_r;
        else if (bus_i.addr == OFS_RSVD16)
            rdata_nxt = rsvd16_r;
        else if (bus_i.addr == OFS_MONCTL0)
            rdata_nxt = monctl0_r;
        else if (bus_i.addr == OFS_MONCTL1)
            rdata_nxt = monctl1_r;
        else if (bus_i.addr == OFS_V0_LIM)
            rdata_nxt = v0lim_r;
        else if (bus_i.addr == OFS_V1_LIM)
            rdata_nxt = v1lim_r;
        else if (bus_i.addr == OFS_T_LIM)
            rdata_nxt = tlim_r;
        else if (bus_i.addr == OFS_CSI_EN)
            rdata_nxt = csien_r;
        else if (bus_i.addr == OFS_SENSE_EN)
            rdata_nxt = senseen_r;
    end

    // read data holds only in the cycle after the strobe
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_o <= RD_UNMAPPED;
        else if (bus_i.rd)
            rdata_o <= rdata_nxt;
        else
            rdata_o <= RD_UNMAPPED;
    end

    // self-test controls
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            test_o <= '0;
        else
        begin
            test_o.forced_error_count            <= selftest_r[FERR_MSB:FERR_LSB];
            test_o.force_active                  <= |selftest_r[FERR_MSB:FERR_LSB];
            test_o.local_selftest_enable         <= selftest_r[LBIST_BIT];
            test_o.legacy_remote_selftest_enable <= selftest_r[RBIST_BIT];
            if (selftest_r[CLKS_MSB])
                test_o.selftest_clock_select <= BSA_CLK_25M;
            else if (selftest_r[CLKS_LSB])
                test_o.selftest_clock_select <= BSA_CLK_50M;
            else
                test_o.selftest_clock_select <= BSA_CLK_EXT;
        end
    end

    // monitor controls; the sensor front end scales by 128 over the code
    assign sensors_on = (monctl0_r[SEN_MSB:SEN_LSB] == SEN_ON);
    assign pin0_on    = sensors_on && monctl0_r[PIN_LSB];
    assign pin1_on    = sensors_on && monctl0_r[PIN_MSB];

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            mon_o <= '0;
        else
        begin
            mon_o.voltage_gain_code <= vgain_r[GAIN_MSB:GAIN_LSB];
            mon_o.gain_applied      <= monctl1_r[GAINEN_BIT] &&
                                       (vgain_r[GAIN_MSB:GAIN_LSB] != GAIN_UNITY);
            mon_o.sensors_on        <= sensors_on;
            mon_o.pin0_sense        <= pin0_on;
            mon_o.pin1_sense        <= pin1_on;
        end
    end

    // readings and error levels come from analog and receive logic
    bsa_sync2 #(.W($bits(bsa_meas_s))) u_meas_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     (meas_i),
        .q_o     (meas_s)
    );

    bsa_sync2 #(.W(CSI_W)) u_csi_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     (csi_err_i),
        .q_o     (csi_s)
    );

    bsa_limit_cmp u_cmp_v0 (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .active_i (pin0_on),
        .level_i  (meas_s.volt0),
        .upper_i  (v0lim_r[HI_MSB:HI_LSB]),
        .lower_i  (v0lim_r[LO_MSB:LO_LSB]),
        .over_o   (chan0_over_flag),
        .under_o  (chan0_under_flag)
    );

    bsa_limit_cmp u_cmp_v1 (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .active_i (pin1_on),
        .level_i  (meas_s.volt1),
        .upper_i  (v1lim_r[HI_MSB:HI_LSB]),
        .lower_i  (v1lim_r[LO_MSB:LO_LSB]),
        .over_o   (chan1_over_flag),
        .under_o  (chan1_under_flag)
    );

    bsa_limit_cmp u_cmp_t (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .active_i (sensors_on),
        .level_i  (meas_s.temp),
        .upper_i  (tlim_r[HI_MSB:HI_LSB]),
        .lower_i  (tlim_r[LO_MSB:LO_LSB]),
        .over_o   (temp_over_flag),
        .under_o  (temp_under_flag)
    );

    assign sense_flags_o = {temp_over_flag, temp_under_flag, chan1_over_flag,
                            chan1_under_flag, chan0_over_flag, chan0_under_flag};

    // gating leaves flags untouched; only the alarms are masked
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sense_alarm_o <= '0;
            csi_alarm_o   <= '0;
        end
        else
        begin
            sense_alarm_o <= sense_flags_o & senseen_r[SENSE_W-1:0];
            csi_alarm_o   <= csi_s & csien_r[CSI_W-1:0];
        end
    end

    sequence s_over0_cause;
        pin0_on && (meas_s.volt0 > v0lim_r[HI_MSB:HI_LSB]);
    endsequence

    a_chan0_over_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        s_over0_cause |=> chan0_over_flag)
        else $error("channel 0 over flag missed");

    a_chan0_under_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        (pin0_on && (meas_s.volt0 < v0lim_r[LO_MSB:LO_LSB])) |=> chan0_under_flag)
        else $error("channel 0 under flag missed");

    a_chan1_off_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
        !pin1_on |=> !chan1_over_flag && !chan1_under_flag)
        else $error("channel 1 flag while not sensing");

    a_temp_over_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        (sensors_on && (meas_s.temp > tlim_r[HI_MSB:HI_LSB])) |=> temp_over_flag)
        else $error("temperature over flag missed");

    a_sense_alarm_gate: assert property (@(posedge clock_i) disable iff (rst_i)
        sense_alarm_o == (($past(sense_flags_o)) & $past(senseen_r[SENSE_W-1:0])))
        else $error("sense alarm not gated by enable");

    a_csi_alarm_gate: assert property (@(posedge clock_i) disable iff (rst_i)
        (!csien_r[NFV_BIT]) |=> !csi_alarm_o[NFV_BIT])
        else $error("missing frame alarm passed while disabled");

    a_force_active: assert property (@(posedge clock_i) disable iff (rst_i)
        (selftest_r[FERR_MSB:FERR_LSB] == 4'h0) |=> !test_o.force_active)
        else $error("error forcing active with zero count");

    a_clock_select: assert property (@(posedge clock_i) disable iff (rst_i)
        selftest_r[CLKS_MSB] |=> test_o.selftest_clock_select == BSA_CLK_25M)
        else $error("upper clock select bit not giving 25 MHz");

    a_read_one_cycle: assert property (@(posedge clock_i) disable iff (rst_i)
        (bus_i.rd && bus_i.addr == OFS_CSI_EN) |=> rdata_o == $past(csien_r))
        else $error("read data wrong for alarm enable");

    // the cycle after reset release still shows reset outputs, so it is skipped
    sequence s_under_t_cause;
        !$past(rst_i) && sensors_on && (meas_s.temp < tlim_r[LO_MSB:LO_LSB]);
    endsequence

    a_temp_under_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        s_under_t_cause |=> temp_under_flag)
        else $error("temperature under flag missed");

    a_chan1_over_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        (pin1_on && (meas_s.volt1 > v1lim_r[HI_MSB:HI_LSB])) |=> chan1_over_flag)
        else $error("channel 1 over flag missed");

    a_chan1_under_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        (pin1_on && (meas_s.volt1 < v1lim_r[LO_MSB:LO_LSB])) |=> chan1_under_flag)
        else $error("channel 1 under flag missed");

    a_chan0_off_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
        !pin0_on |=> !chan0_over_flag && !chan0_under_flag)
        else $error("channel 0 flag while not sensing");

    a_temp_off_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
        !sensors_on |=> !temp_over_flag && !temp_under_flag)
        else $error("temperature flag while sensors off");

    a_local_selftest: assert property (@(posedge clock_i) disable iff (rst_i)
        selftest_r[LBIST_BIT] |=> test_o.local_selftest_enable)
        else $error("local self-test enable not passed on");

    a_legacy_remote: assert property (@(posedge clock_i) disable iff (rst_i)
        selftest_r[RBIST_BIT] |=> test_o.legacy_remote_selftest_enable)
        else $error("legacy remote self-test enable not passed on");

    a_force_on: assert property (@(posedge clock_i) disable iff (rst_i)
        (selftest_r[FERR_MSB:FERR_LSB] != 4'h0) |=> test_o.force_active)
        else $error("error forcing idle with nonzero count");

    a_sensor_enable: assert property (@(posedge clock_i) disable iff (rst_i)
        (!$past(rst_i) && (monctl0_r[SEN_MSB:SEN_LSB] == SEN_ON)) |=> mon_o.sensors_on)
        else $error("sensors not enabled by field");

    a_pin0_select: assert property (@(posedge clock_i) disable iff (rst_i)
        pin0_on |=> mon_o.pin0_sense)
        else $error("pin 0 sensing not selected");

    a_gain_enable: assert property (@(posedge clock_i) disable iff (rst_i)
        !monctl1_r[GAINEN_BIT] |=> !mon_o.gain_applied)
        else $error("gain applied while gain enable clear");

    a_gain_code: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(rst_i) |=> (mon_o.voltage_gain_code == $past(vgain_r[GAIN_MSB:GAIN_LSB])))
        else $error("gain code not passed on");

    a_temp_alarm_mask: assert property (@(posedge clock_i) disable iff (rst_i)
        !senseen_r[T_OV_BIT] |=> !sense_alarm_o[T_OV_BIT])
        else $error("temperature over alarm passed while disabled");

    a_chan1_alarm_mask: assert property (@(posedge clock_i) disable iff (rst_i)
        !senseen_r[V1_OV_BIT] |=> !sense_alarm_o[V1_OV_BIT])
        else $error("channel 1 over alarm passed while disabled");

endmodule : bsa_config_regs

// ===== tb_bsa_config_regs.sv
/*
 * Self-checking testbench for the self-test and sensor alarm configuration
 * bank: register reset values, write/read-back, decoded test and monitor
 * outputs, limit flags, alarm gating and unmapped accesses.
 * Assumes the package bsa_pkg and the module bsa_config_regs are compiled first.
 */
`timescale 1ns/10ps
module tb_bsa_config_regs;
    import bsa_pkg::*;

    logic              clock_i;
    logic              rst_i;
    bsa_bus_s          bus;
    logic [7:0]        rdata;
    bsa_meas_s         meas;
    logic [5:0]        csi_err;
    bsa_test_s         test_out;
    bsa_mon_s          mon_out;
    logic [5:0]        flags;
    logic [5:0]        salarm;
    logic [5:0]        calarm;
    int                errors;
    int                n_checks;
    int                cycles = 0;

    bsa_config_regs u_bsa_config_regs (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .bus_i         (bus),
        .rdata_o       (rdata),
        .meas_i        (meas),
        .csi_err_i     (csi_err),
        .test_o        (test_out),
        .mon_o         (mon_out),
        .sense_flags_o (flags),
        .sense_alarm_o (salarm),
        .csi_alarm_o   (calarm)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // a hung handshake never reaches the closing report otherwise
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clock_i);
        bus.wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clock_i);
        bus.rd   <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : settle

    task automatic test_reset();
        logic [7:0] ofs [12];
        logic [7:0] val [12];
        ofs = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B,
                8'h1C, 8'h1D, 8'h13, 8'h1E};
        val = '{8'h00, 8'h20, 8'h18, 8'h0C, 8'h80, 8'h62, 8'h62, 8'h62,
                8'h3F, 8'h00, 8'h00, 8'h00};
        settle(1);
        chk({7'h00, test_out}, 16'h0000);
        chk({5'h00, mon_out}, 16'h020C);
        for (int i = 0; i < 12; i++)
            rd_chk(ofs[i], val[i]);
        $display("test reset values done");
    endtask : test_reset

    task automatic test_selftest();
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = i[1:0];
            wr_reg(8'h14, {4'h1, 1'b0, c, 1'b1});
            settle(2);
            chk({7'h00, test_out}, {7'h00, 4'h1, 1'b0, (c[1] ? 2'b10 : c), 2'b11});
        end
        wr_reg(8'h14, 8'h08);
        settle(2);
        chk({7'h00, test_out}, 16'h0010);
        wr_reg(8'h14, 8'hF0);
        settle(2);
        chk({7'h00, test_out}, 16'h01E1);
        rd_chk(8'h14, 8'hF0);
        $display("test self-test control done");
    endtask : test_selftest

    task automatic test_monitor();
        logic [1:0] p;
        wr_reg(8'h15, 8'hC0);
        settle(2);
        chk({5'h00, mon_out}, 16'h040C);
        rd_chk(8'h15, 8'hC0);
        wr_reg(8'h18, 8'h00);
        settle(2);
        chk({5'h00, mon_out}, 16'h0404);
        wr_reg(8'h18, 8'h80);
        wr_reg(8'h15, 8'h20);
        for (int i = 0; i < 4; i++)
        begin
            p = i[1:0];
            wr_reg(8'h17, {6'h03, p});
            settle(2);
            chk({5'h00, mon_out}, {5'h00, 7'h20, 2'b11, p[0], p[1]});
        end
        wr_reg(8'h17, 8'h03);
        settle(2);
        chk({5'h00, mon_out}, 16'h0208);
        $display("test monitor control done");
    endtask : test_monitor

    task automatic flag_case(input logic [7:0] m0, input bsa_meas_s m,
                             input logic [5:0] exp);
        wr_reg(8'h17, m0);
        meas <= m;
        settle(6);
        chk({10'h000, flags}, {10'h000, exp});
    endtask : flag_case

    task automatic test_flags();
        flag_case(8'h0D, '{3'h7, 3'h1, 3'h4}, 6'h02);
        flag_case(8'h0E, '{3'h7, 3'h1, 3'h4}, 6'h04);
        flag_case(8'h0F, '{3'h6, 3'h2, 3'h1}, 6'h10);
        flag_case(8'h0F, '{3'h1, 3'h7, 3'h7}, 6'h29);
        chk({10'h000, salarm}, 16'h0000);
        wr_reg(8'h1D, 8'h3F);
        settle(2);
        chk({10'h000, salarm}, 16'h0029);
        wr_reg(8'h1D, 8'h21);
        settle(2);
        chk({10'h000, salarm}, 16'h0021);
        chk({10'h000, flags}, 16'h0029);
        wr_reg(8'h19, 8'h70);
        wr_reg(8'h1A, 8'h74);
        wr_reg(8'h1B, 8'h07);
        settle(4);
        chk({10'h000, flags}, 16'h0020);
        flag_case(8'h0B, '{3'h1, 3'h7, 3'h7}, 6'h00);
        $display("test limit flags and alarms done");
    endtask : test_flags

    task automatic test_csi();
        @(posedge clock_i);
        csi_err <= 6'h3F;
        settle(5);
        chk({10'h000, calarm}, 16'h003F);
        wr_reg(8'h1C, 8'h15);
        settle(2);
        chk({10'h000, calarm}, 16'h0015);
        @(posedge clock_i);
        csi_err <= 6'h2A;
        settle(5);
        chk({10'h000, calarm}, 16'h0000);
        wr_reg(8'h1C, 8'hFF);
        settle(2);
        chk({10'h000, calarm}, 16'h002A);
        rd_chk(8'h1C, 8'hFF);
        $display("test receive alarm enables done");
    endtask : test_csi

    task automatic test_unmapped();
        wr_reg(8'h1E, 8'h55);
        rd_chk(8'h1E, 8'h00);
        wr_reg(8'h16, 8'hA5);
        rd_chk(8'h16, 8'hA5);
        rd_chk(8'h13, 8'h00);
        // a second reset in mid-run must restore the defaults
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h1D, 8'h00);
        $display("test unmapped and re-reset done");
    endtask : test_unmapped

    initial
    begin
        rst_i    = 1'b1;
        bus      = '0;
        meas     = '0;
        csi_err  = 6'h00;
        errors   = 0;
        n_checks = 0;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        test_reset();
        test_selftest();
        test_monitor();
        test_flags();
        test_csi();
        test_unmapped();
        close_out();
    end

endmodule : tb_bsa_config_regs
